// ---- core/ubec_pkg.sv ----
/*
  Shared constants and types for the bulk endpoint control block:
  register addresses, bit positions, reset values and link carriers.
  Assumes an 8-bit register port with 16-bit addresses.
*/
package ubec_pkg;

  // register addresses
  localparam logic [15:0] UBEC_ADDR_INDEX   = 16'hde0e;
  localparam logic [15:0] UBEC_ADDR_IN_MAX  = 16'hde10;
  localparam logic [15:0] UBEC_ADDR_IN_CSL  = 16'hde11;
  localparam logic [15:0] UBEC_ADDR_IN_CSH  = 16'hde12;
  localparam logic [15:0] UBEC_ADDR_OUT_MAX = 16'hde13;
  localparam logic [15:0] UBEC_ADDR_OUT_CSL = 16'hde14;
  localparam logic [15:0] UBEC_ADDR_OUT_CSH = 16'hde15;
  // fifo ports sit at page base + 2*ep
  localparam logic [11:0] UBEC_FIFO_PAGE    = 12'hde2;

  // in_ep_ctrl_status_low bits
  localparam int UBEC_ICL_LOADED   = 0;
  localparam int UBEC_ICL_PRESENT  = 1;
  localparam int UBEC_ICL_UNDERRUN = 2;
  localparam int UBEC_ICL_FLUSH    = 3;
  localparam int UBEC_ICL_STALL    = 4;
  localparam int UBEC_ICL_SENT     = 5;
  localparam int UBEC_ICL_TOGRST   = 6;
  // in_ep_ctrl_status_high bits
  localparam int UBEC_ICH_DBL      = 0;
  localparam int UBEC_ICH_FORCE    = 3;
  localparam int UBEC_ICH_RSV_LO   = 4;
  localparam int UBEC_ICH_RSV_HI   = 5;
  localparam int UBEC_ICH_ISO      = 6;
  localparam int UBEC_ICH_AUTO     = 7;
  // out_ep_ctrl_status_low bits
  localparam int UBEC_OCL_WAITING  = 0;
  localparam int UBEC_OCL_FULL     = 1;
  localparam int UBEC_OCL_OVERRUN  = 2;
  localparam int UBEC_OCL_ERROR    = 3;
  localparam int UBEC_OCL_FLUSH    = 4;
  localparam int UBEC_OCL_STALL    = 5;
  localparam int UBEC_OCL_SENT     = 6;
  localparam int UBEC_OCL_TOGRST   = 7;
  // out high register bits
  localparam int UBEC_OCH_DBL      = 0;
  localparam int UBEC_OCH_ISO      = 6;

  // reset values
  localparam logic [1:0] UBEC_IN_RSV_RESET  = 2'h2;
  localparam logic [1:0] UBEC_OUT_RSV_RESET = 2'h0;
  localparam logic [7:0] UBEC_MAX_RESET     = 8'h00;

  // max packet unit is 8 bytes
  localparam int UBEC_UNIT_SHIFT = 3;

  typedef enum logic [2:0] {
    UBEC_EV_IN_TOKEN,
    UBEC_EV_IN_ACK,
    UBEC_EV_IN_NOACK,
    UBEC_EV_OUT_OK,
    UBEC_EV_OUT_BAD
  } ubec_ev_kind_t;

  typedef enum logic [2:0] {
    UBEC_HS_NONE,
    UBEC_HS_DATA,
    UBEC_HS_ZLP,
    UBEC_HS_NAK,
    UBEC_HS_STALL,
    UBEC_HS_ACK
  } ubec_hs_t;

  typedef struct packed {
    logic          valid;
    logic [2:0]    ep;
    ubec_ev_kind_t kind;
    logic          data1;
  } ubec_link_ev_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] ep;
    ubec_hs_t   hs;
    logic       data1;
  } ubec_link_rsp_t;

  typedef struct packed {
    logic       push;
    logic       pop;
    logic [2:0] ep;
    logic [7:0] data;
  } ubec_fifo_req_t;

endpackage

// ---- core/ubec_slot_count.sv ----
/*
  Packet slot counter for one endpoint direction: counts whole packets
  held in the FIFO, one slot or two with double buffering.
  Assumes push and pop are one-cycle pulses on sys_clk.
*/
`timescale 1ns/100ps
module ubec_slot_count
  import ubec_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // events
  input  wire logic       push,
  input  wire logic       pop,
  input  wire logic       clear,
  input  wire logic       dbl,
  // state
  output logic [1:0]      count,
  output logic            full,
  output logic            nonempty
);

  logic [1:0] count_q;
  logic [1:0] count_d;
  logic [1:0] cap;
  logic       push_ok;
  logic       pop_ok;

  assign cap      = dbl ? 2'h2 : 2'h1;
  assign full     = (count_q >= cap);
  assign nonempty = (count_q != 2'h0);
  assign push_ok  = push && !full;
  assign pop_ok   = pop && nonempty;
  assign count_d  = clear ? 2'h0 : 2'(count_q + {1'b0, push_ok} - {1'b0, pop_ok});
  assign count    = count_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 2'h0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule

// ---- core/ubec_ctrl.sv ----
/*
  Control and status logic of the non-control endpoints 1..NUM_EP of a
  full-speed device: handshake flags, stall, flush, data toggle, type,
  double buffering, max packet sizes and error flags.
  Assumes a packet engine on sys_clk that reports tokens as one-cycle
  events and an external FIFO that shows each OUT head byte.
*/
// Design decision made here: the strobed register port.
// Behaviour
// - toggle reset bit forces DATA0, self-clears
// - in stall sent: flag, flush, event
// - out stall sent: flag, event; firmware clears
// - in stall bit stalls bulk IN tokens
// - out stall bit stalls bulk OUT tokens
// - in flush drops next packet, self-clears
// - out flush drops next packet, self-clears
// - iso IN empty: zero-length packet, underrun
// - bulk IN NAK sets underrun flag
// - packet-present reads one when queue nonempty
// - in loaded cleared and event when sent
// - auto-mark loaded after max-size packet loaded
// - high bit 6 selects iso type
// - forced toggle switches and flushes without ACK
// - high bit 0 enables IN double buffer
// - out max size in 8-byte units
// - iso OUT CRC error flag, cleared on pop
// - iso OUT overrun when FIFO cannot store
// - fifo-full reads one when OUT full
// - OUT packet sets waiting flag and event
// - fifo port read pops, write pushes
`timescale 1ns/100ps
module ubec_ctrl
  import ubec_pkg::*;
#(
  parameter int NUM_EP = 5
) (
  // clock and reset
  input  wire logic           sys_clk,
  input  wire logic           nrst,
  // register port
  input  wire logic [15:0]    reg_addr,
  input  wire logic [7:0]     reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic [7:0]          reg_rdata,
  // packet engine
  input  wire ubec_link_ev_t  link_ev,
  output ubec_link_rsp_t      link_rsp,
  // fifo memory
  output ubec_fifo_req_t      fifo_req,
  input  wire logic [7:0]     fifo_head [1:NUM_EP],
  // endpoint events to the interrupt block
  output logic [NUM_EP:1]     in_ep_irq_req,
  output logic [NUM_EP:1]     out_ep_irq_req
);

  logic             rst_meta_q;
  logic             rst_n;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // register decode
  logic [3:0]       sel_q;
  logic             sel_ok;
  logic             hit_in_max;
  logic             hit_in_csl;
  logic             hit_in_csh;
  logic             hit_out_max;
  logic             hit_out_csl;
  logic             hit_out_csh;
  logic             hit_fifo;
  logic [2:0]       fifo_ep;

  assign sel_ok      = (sel_q != 4'h0) && (sel_q <= 4'(NUM_EP));
  assign hit_in_max  = (reg_addr == UBEC_ADDR_IN_MAX) && sel_ok;
  assign hit_in_csl  = (reg_addr == UBEC_ADDR_IN_CSL) && sel_ok;
  assign hit_in_csh  = (reg_addr == UBEC_ADDR_IN_CSH) && sel_ok;
  assign hit_out_max = (reg_addr == UBEC_ADDR_OUT_MAX) && sel_ok;
  assign hit_out_csl = (reg_addr == UBEC_ADDR_OUT_CSL) && sel_ok;
  assign hit_out_csh = (reg_addr == UBEC_ADDR_OUT_CSH) && sel_ok;
  assign fifo_ep     = reg_addr[3:1];
  assign hit_fifo    = (reg_addr[15:4] == UBEC_FIFO_PAGE) && !reg_addr[0]
                       && (fifo_ep != 3'h0) && (fifo_ep <= 3'(NUM_EP));

  // fifo port: read removes a byte, write appends one
  assign fifo_req.push = reg_wr && hit_fifo;
  assign fifo_req.pop  = reg_rd && hit_fifo;
  assign fifo_req.ep   = fifo_ep;
  assign fifo_req.data = reg_wdata;

  // selector is software's duty to keep in range
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= 4'h0;
    end else if (reg_wr && reg_addr == UBEC_ADDR_INDEX) begin
      sel_q <= reg_wdata[3:0];
    end
  end

  // per endpoint state
  logic [NUM_EP:1]  in_stall_q;
  logic [NUM_EP:1]  in_sent_q;
  logic [NUM_EP:1]  in_underrun_q;
  logic [NUM_EP:1]  in_toggle_q;
  logic [NUM_EP:1]  in_auto_q;
  logic [NUM_EP:1]  in_iso_q;
  logic [NUM_EP:1]  in_force_q;
  logic [NUM_EP:1]  in_dbl_q;
  logic [NUM_EP:1]  in_full;
  logic [NUM_EP:1]  in_nonempty;
  logic [NUM_EP:1]  out_stall_q;
  logic [NUM_EP:1]  out_sent_q;
  logic [NUM_EP:1]  out_overrun_q;
  logic [NUM_EP:1]  out_err_q;
  logic [NUM_EP:1]  out_toggle_q;
  logic [NUM_EP:1]  out_iso_q;
  logic [NUM_EP:1]  out_dbl_q;
  logic [NUM_EP:1]  out_full;
  logic [NUM_EP:1]  out_nonempty;
  logic [1:0]       in_rsv_q  [1:NUM_EP];
  logic [1:0]       out_rsv_q [1:NUM_EP];
  logic [7:0]       in_max_q  [1:NUM_EP];
  logic [7:0]       out_max_q [1:NUM_EP];
  logic [10:0]      in_bytes_q [1:NUM_EP];
  ubec_hs_t         ep_hs [1:NUM_EP];
  logic             ev_ok;

  assign ev_ok = link_ev.valid && (link_ev.ep != 3'h0) && (link_ev.ep <= 3'(NUM_EP));

  for (genvar e = 1; e <= NUM_EP; e++) begin : g_ep
    logic        wsel;
    logic        ev_hit;
    logic        in_token;
    logic        in_stalling;
    logic        stall_in;
    logic        in_send;
    logic        in_empty_tok;
    logic        in_acked;
    logic        in_noack;
    logic        in_done;
    logic        in_flip;
    logic        wr_icl;
    logic        wr_ich;
    logic        byte_wr;
    logic [10:0] max_bytes;
    logic        auto_push;
    logic        in_push;
    logic        in_pop;
    logic        out_rx;
    logic        out_stalling;
    logic        stall_out;
    logic        pid_match;
    logic        out_push;
    logic        out_pop;
    logic        out_flip;
    logic        wr_ocl;
    logic        wr_och;

    assign wsel         = (sel_q == 4'(e));
    assign ev_hit       = ev_ok && (link_ev.ep == 3'(e));
    assign wr_icl       = reg_wr && hit_in_csl && wsel;
    assign wr_ich       = reg_wr && hit_in_csh && wsel;
    assign wr_ocl       = reg_wr && hit_out_csl && wsel;
    assign wr_och       = reg_wr && hit_out_csh && wsel;

    // in direction
    assign in_token     = ev_hit && (link_ev.kind == UBEC_EV_IN_TOKEN);
    assign in_stalling  = in_stall_q[e] && !in_iso_q[e];
    assign stall_in     = in_token && in_stalling;
    assign in_send      = in_token && !in_stalling && in_nonempty[e];
    assign in_empty_tok = in_token && !in_stalling && !in_nonempty[e];
    assign in_acked     = ev_hit && (link_ev.kind == UBEC_EV_IN_ACK) && !in_iso_q[e];
    assign in_noack     = ev_hit && (link_ev.kind == UBEC_EV_IN_NOACK) && !in_iso_q[e]
                          && in_force_q[e];
    // iso data gets no handshake, so it leaves on sending
    assign in_done      = in_acked || in_noack || (in_send && in_iso_q[e]);
    assign in_flip      = in_acked || (in_done && in_force_q[e]);
    assign byte_wr      = fifo_req.push && (fifo_ep == 3'(e));
    assign max_bytes    = {3'h0, in_max_q[e]} << UBEC_UNIT_SHIFT;
    assign auto_push    = byte_wr && in_auto_q[e] && (in_max_q[e] != 8'h00)
                          && (11'(in_bytes_q[e] + 11'h1) == max_bytes);
    assign in_push      = (wr_icl && reg_wdata[UBEC_ICL_LOADED]) || auto_push;
    assign in_pop       = in_done || (wr_icl && reg_wdata[UBEC_ICL_FLUSH]);
    assign in_ep_irq_req[e] = in_done || stall_in;

    ubec_slot_count u_in_slots (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .push     (in_push),
      .pop      (in_pop),
      .clear    (stall_in),
      .dbl      (in_dbl_q[e]),
      .count    (),
      .full     (in_full[e]),
      .nonempty (in_nonempty[e])
    );

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        in_stall_q[e]    <= 1'b0;
        in_sent_q[e]     <= 1'b0;
        in_underrun_q[e] <= 1'b0;
        in_toggle_q[e]   <= 1'b0;
      end else begin
        if (wr_icl) begin
          in_stall_q[e] <= reg_wdata[UBEC_ICL_STALL];
        end
        if (stall_in) begin
          in_sent_q[e] <= 1'b1;
        end else if (wr_icl && !reg_wdata[UBEC_ICL_SENT]) begin
          in_sent_q[e] <= 1'b0;
        end
        if (in_empty_tok) begin
          in_underrun_q[e] <= 1'b1;
        end else if (wr_icl && !reg_wdata[UBEC_ICL_UNDERRUN]) begin
          in_underrun_q[e] <= 1'b0;
        end
        if (wr_icl && reg_wdata[UBEC_ICL_TOGRST]) begin
          in_toggle_q[e] <= 1'b0;
        end else if (in_flip) begin
          in_toggle_q[e] <= !in_toggle_q[e];
        end
      end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        in_auto_q[e]  <= 1'b0;
        in_iso_q[e]   <= 1'b0;
        in_force_q[e] <= 1'b0;
        in_dbl_q[e]   <= 1'b0;
        in_rsv_q[e]   <= UBEC_IN_RSV_RESET;
        in_max_q[e]   <= UBEC_MAX_RESET;
      end else begin
        if (wr_ich) begin
          in_auto_q[e]  <= reg_wdata[UBEC_ICH_AUTO];
          in_iso_q[e]   <= reg_wdata[UBEC_ICH_ISO];
          in_force_q[e] <= reg_wdata[UBEC_ICH_FORCE];
          in_dbl_q[e]   <= reg_wdata[UBEC_ICH_DBL];
          in_rsv_q[e]   <= reg_wdata[UBEC_ICH_RSV_HI:UBEC_ICH_RSV_LO];
        end
        if (reg_wr && hit_in_max && wsel) begin
          in_max_q[e] <= reg_wdata;
        end
      end
    end

    // bytes loaded since the last packet was marked
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        in_bytes_q[e] <= 11'h0;
      end else if (in_push) begin
        in_bytes_q[e] <= 11'h0;
      end else if (byte_wr) begin
        in_bytes_q[e] <= 11'(in_bytes_q[e] + 11'h1);
      end
    end

    // out direction
    assign out_rx       = ev_hit && (link_ev.kind == UBEC_EV_OUT_OK
                                     || link_ev.kind == UBEC_EV_OUT_BAD);
    assign out_stalling = out_stall_q[e] && !out_iso_q[e];
    assign stall_out    = out_rx && out_stalling;
    assign pid_match    = (link_ev.data1 == out_toggle_q[e]);
    // bulk repeats with a stale toggle are acked but dropped
    assign out_flip     = ev_hit && (link_ev.kind == UBEC_EV_OUT_OK) && !out_iso_q[e]
                          && !out_stalling && !out_full[e] && pid_match;
    assign out_push     = out_flip || (out_rx && out_iso_q[e] && !out_full[e]);
    assign out_pop      = wr_ocl && ((!reg_wdata[UBEC_OCL_WAITING] && out_nonempty[e])
                          || reg_wdata[UBEC_OCL_FLUSH]);
    assign out_ep_irq_req[e] = out_push || stall_out;

    ubec_slot_count u_out_slots (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .push     (out_push),
      .pop      (out_pop),
      .clear    (1'b0),
      .dbl      (out_dbl_q[e]),
      .count    (),
      .full     (out_full[e]),
      .nonempty (out_nonempty[e])
    );

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        out_stall_q[e]   <= 1'b0;
        out_sent_q[e]    <= 1'b0;
        out_overrun_q[e] <= 1'b0;
        out_err_q[e]     <= 1'b0;
        out_toggle_q[e]  <= 1'b0;
      end else begin
        if (wr_ocl) begin
          out_stall_q[e] <= reg_wdata[UBEC_OCL_STALL];
        end
        if (stall_out) begin
          out_sent_q[e] <= 1'b1;
        end else if (wr_ocl && !reg_wdata[UBEC_OCL_SENT]) begin
          out_sent_q[e] <= 1'b0;
        end
        if (out_rx && out_iso_q[e] && out_full[e]) begin
          out_overrun_q[e] <= 1'b1;
        end else if (wr_ocl && !reg_wdata[UBEC_OCL_OVERRUN]) begin
          out_overrun_q[e] <= 1'b0;
        end
        if (out_push && link_ev.kind == UBEC_EV_OUT_BAD) begin
          out_err_q[e] <= 1'b1;
        end else if (out_pop) begin
          out_err_q[e] <= 1'b0;
        end
        if (wr_ocl && reg_wdata[UBEC_OCL_TOGRST]) begin
          out_toggle_q[e] <= 1'b0;
        end else if (out_flip) begin
          out_toggle_q[e] <= !out_toggle_q[e];
        end
      end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        out_iso_q[e] <= 1'b0;
        out_dbl_q[e] <= 1'b0;
        out_rsv_q[e] <= UBEC_OUT_RSV_RESET;
        out_max_q[e] <= UBEC_MAX_RESET;
      end else begin
        if (wr_och) begin
          out_iso_q[e] <= reg_wdata[UBEC_OCH_ISO];
          out_dbl_q[e] <= reg_wdata[UBEC_OCH_DBL];
          out_rsv_q[e] <= reg_wdata[UBEC_ICH_RSV_HI:UBEC_ICH_RSV_LO];
        end
        if (reg_wr && hit_out_max && wsel) begin
          out_max_q[e] <= reg_wdata;
        end
      end
    end

    // handshake chosen for this endpoint's event
    assign ep_hs[e] = (stall_in || stall_out)      ? UBEC_HS_STALL :
                      in_send                      ? UBEC_HS_DATA  :
                      (in_empty_tok && in_iso_q[e]) ? UBEC_HS_ZLP  :
                      in_empty_tok                 ? UBEC_HS_NAK   :
                      (out_rx && !out_iso_q[e] && link_ev.kind == UBEC_EV_OUT_OK)
                        ? (out_full[e] ? UBEC_HS_NAK : UBEC_HS_ACK)
                        : UBEC_HS_NONE;
  end

  // link answer, registered
  ubec_hs_t         rsp_hs;
  logic [2:0]       sel_ep;
  logic [7:0]       icl_rd;
  logic [7:0]       ich_rd;
  logic [7:0]       ocl_rd;
  logic [7:0]       och_rd;
  logic [7:0]       rd_mux;

  assign rsp_hs = ev_ok ? ep_hs[link_ev.ep] : UBEC_HS_NONE;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_rsp <= '0;
    end else begin
      link_rsp.valid <= (rsp_hs != UBEC_HS_NONE);
      link_rsp.ep    <= link_ev.ep;
      link_rsp.hs    <= rsp_hs;
      link_rsp.data1 <= ev_ok ? in_toggle_q[link_ev.ep] : 1'b0;
    end
  end

  // read mux; self-clearing bits always read zero
  assign sel_ep = sel_ok ? sel_q[2:0] : 3'h1;
  assign icl_rd = {2'h0, in_sent_q[sel_ep], in_stall_q[sel_ep], 1'b0,
                   in_underrun_q[sel_ep], in_nonempty[sel_ep], in_full[sel_ep]};
  assign ich_rd = {in_auto_q[sel_ep], in_iso_q[sel_ep], in_rsv_q[sel_ep],
                   in_force_q[sel_ep], 2'h0, in_dbl_q[sel_ep]};
  assign ocl_rd = {1'b0, out_sent_q[sel_ep], out_stall_q[sel_ep], 1'b0,
                   out_err_q[sel_ep], out_overrun_q[sel_ep], out_full[sel_ep],
                   out_nonempty[sel_ep]};
  assign och_rd = {1'b0, out_iso_q[sel_ep], out_rsv_q[sel_ep], 3'h0, out_dbl_q[sel_ep]};
  assign rd_mux = (reg_addr == UBEC_ADDR_INDEX) ? {4'h0, sel_q} :
                  hit_in_max  ? in_max_q[sel_ep]  :
                  hit_in_csl  ? icl_rd            :
                  hit_in_csh  ? ich_rd            :
                  hit_out_max ? out_max_q[sel_ep] :
                  hit_out_csl ? ocl_rd            :
                  hit_out_csh ? och_rd            :
                  hit_fifo    ? fifo_head[fifo_ep] : 8'h00;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

endmodule

// ---- bench/ubec_ctrl_properties.sv ----
/*
  Port-level checker for ubec_ctrl, bound to every instance.
  Assumes the register port and link event contract of the block.
*/
`timescale 1ns/100ps
module ubec_ctrl_properties
  import ubec_pkg::*;
#(
  parameter int NUM_EP = 5
) (
  // clock and reset
  input wire logic           sys_clk,
  input wire logic           nrst,
  // register port
  input wire logic [15:0]    reg_addr,
  input wire logic [7:0]     reg_wdata,
  input wire logic           reg_wr,
  input wire logic           reg_rd,
  input wire logic [7:0]     reg_rdata,
  // link and fifo
  input wire ubec_link_ev_t  link_ev,
  input wire ubec_link_rsp_t link_rsp,
  input wire ubec_fifo_req_t fifo_req,
  input wire logic [7:0]     fifo_head [1:NUM_EP],
  // endpoint events
  input wire logic [NUM_EP:1] in_ep_irq_req,
  input wire logic [NUM_EP:1] out_ep_irq_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_rd(logic [15:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_ev(ubec_ev_kind_t k);
    link_ev.valid && link_ev.kind == k;
  endsequence

  chk_in_selfclr: assert property (
    s_rd(UBEC_ADDR_IN_CSL) |=> !reg_rdata[UBEC_ICL_TOGRST] && !reg_rdata[UBEC_ICL_FLUSH])
    else $error("in low self-clearing bit read as one");
  chk_out_selfclr: assert property (
    s_rd(UBEC_ADDR_OUT_CSL) |=> !reg_rdata[UBEC_OCL_TOGRST] && !reg_rdata[UBEC_OCL_FLUSH])
    else $error("out low self-clearing bit read as one");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  chk_fifo_push: assert property (
    fifo_req.push |-> reg_wr && fifo_req.data == reg_wdata)
    else $error("fifo push without port write");
  chk_fifo_pop: assert property (
    s_rd({UBEC_FIFO_PAGE, 4'h2}) |-> fifo_req.pop && fifo_req.ep == 3'h1)
    else $error("fifo port read did not pop");
  chk_rsp_cause: assert property (
    link_rsp.valid |-> $past(link_ev.valid) && link_rsp.ep == $past(link_ev.ep))
    else $error("answer without token");
  chk_in_answer: assert property (
    s_ev(UBEC_EV_IN_TOKEN) ##0 link_ev.ep inside {[1:5]} |=> link_rsp.valid &&
      link_rsp.hs inside {UBEC_HS_DATA, UBEC_HS_ZLP, UBEC_HS_NAK, UBEC_HS_STALL})
    else $error("in token not answered");
  chk_ack_quiet: assert property (
    s_ev(UBEC_EV_IN_ACK) or s_ev(UBEC_EV_IN_NOACK) |=> !link_rsp.valid)
    else $error("answer to host handshake");
  chk_ep0_quiet: assert property (
    link_ev.valid && link_ev.ep == 3'h0 |=> !link_rsp.valid)
    else $error("answer for endpoint zero");
  chk_out_irq: assert property (
    out_ep_irq_req != '0 |-> link_ev.valid && $onehot(out_ep_irq_req))
    else $error("out event without packet");
  chk_in_irq: assert property (
    in_ep_irq_req != '0 |-> $onehot(in_ep_irq_req) && (link_ev.valid || $past(link_ev.valid)))
    else $error("in event without transfer");
endmodule

bind ubec_ctrl ubec_ctrl_properties #(.NUM_EP(NUM_EP)) u_chk (.sys_clk, .nrst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_ev, .link_rsp, .fifo_req, .fifo_head,
  .in_ep_irq_req, .out_ep_irq_req);

// ---- bench/ubec_host_model.sv ----
/*
  Host side of the link: sends tokens and handshakes as one-cycle
  events and takes the block's answer in the cycle after.
  Assumes the caller keeps handshakes after a data answer.
*/
`timescale 1ns/100ps
module ubec_host_model
  import ubec_pkg::*;
(
  // clock
  input wire logic           sys_clk,
  // link
  input wire ubec_link_rsp_t link_rsp,
  output ubec_link_ev_t      link_ev
);
  ubec_link_rsp_t last;

  initial link_ev = '0;

  task automatic send(ubec_ev_kind_t k, logic [2:0] e, logic d);
    @(posedge sys_clk);
    link_ev <= '{valid: 1'b1, ep: e, kind: k, data1: d};
    @(posedge sys_clk);
    link_ev <= '0;
    #1 last = link_rsp;
  endtask
endmodule

// ---- bench/test_usb_bulk_endpoint_control.sv ----
/*
  Register and link tests of ubec_ctrl on endpoint 1.
  Assumes the host model and a static OUT fifo head per endpoint.
*/
`timescale 1ns/100ps
module test_usb_bulk_endpoint_control
  import ubec_pkg::*;
;
  localparam logic [15:0] IDX = UBEC_ADDR_INDEX;
  localparam logic [15:0] IMX = UBEC_ADDR_IN_MAX;
  localparam logic [15:0] ICL = UBEC_ADDR_IN_CSL;
  localparam logic [15:0] ICH = UBEC_ADDR_IN_CSH;
  localparam logic [15:0] OMX = UBEC_ADDR_OUT_MAX;
  localparam logic [15:0] OCL = UBEC_ADDR_OUT_CSL;
  localparam logic [15:0] OCH = UBEC_ADDR_OUT_CSH;
  localparam logic [15:0] FP1 = {UBEC_FIFO_PAGE, 4'h2};

  logic           sys_clk = 1'b0;
  logic           nrst = 1'b0;
  logic           reg_wr = 1'b0;
  logic           reg_rd = 1'b0;
  logic [15:0]    reg_addr = '0;
  logic [7:0]     reg_wdata = '0;
  logic [7:0]     reg_rdata;
  ubec_link_ev_t  link_ev;
  ubec_link_rsp_t link_rsp;
  ubec_fifo_req_t fifo_req;
  logic [7:0]     fh [1:5];
  logic [5:1]     iq;
  logic [5:1]     oq;
  int             ni = 0;
  int             no = 0;
  int             n_mismatch = 0;
  int             tests_run = 0;

  always #50 sys_clk = ~sys_clk;
  // endpoint 1 event counts
  always @(posedge sys_clk) begin
    ni <= ni + int'(iq[1]);
    no <= no + int'(oq[1]);
  end
  initial for (int i = 1; i <= 5; i++) fh[i] = 8'ha0 + 8'(i);

  ubec_ctrl #(.NUM_EP(5)) dut (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .link_ev, .link_rsp, .fifo_req, .fifo_head(fh), .in_ep_irq_req(iq),
    .out_ep_irq_req(oq));
  ubec_host_model host (.sys_clk, .link_rsp, .link_ev);

  task ck(logic [7:0] g, logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(logic [15:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(logic [15:0] a, logic [7:0] m, logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 ck(reg_rdata & m, e);
  endtask
  task hs(ubec_ev_kind_t k, logic d, ubec_hs_t h);
    host.send(k, 3'h1, d);
    ck({4'h0, host.last.valid, host.last.hs}, {4'h0, 1'b1, h});
  endtask
  task ld;
    wr(FP1, 8'h11);
    wr(ICL, 8'h01);
  endtask
  task close_out;
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #1000000;
    n_mismatch++;
    close_out;
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    wr(IDX, 8'h01);
    rd(ICH, 8'hff, 8'h20);
    rd(ICL, 8'hff, 8'h00);
    rd(OCL, 8'hff, 8'h00);
    rd(OMX, 8'hff, 8'h00);
    rd(16'hde30, 8'hff, 8'h00);
    wr(OMX, 8'h08);
    rd(OMX, 8'hff, 8'h08);
    wr(IDX, 8'h00);
    rd(OMX, 8'hff, 8'h00);
    wr(IDX, 8'h01);
    host.send(UBEC_EV_IN_TOKEN, 3'h0, 1'b0);
    ck({7'h0, host.last.valid}, 8'h00);
    // empty bulk endpoint
    hs(UBEC_EV_IN_TOKEN, 1'b0, UBEC_HS_NAK);
    rd(ICL, 8'h04, 8'h04);
    wr(ICL, 8'h00);
    rd(ICL, 8'h04, 8'h00);
    // toggle sequence with toggle reset
    ld;
    rd(ICL, 8'h03, 8'h03);
    hs(UBEC_EV_IN_TOKEN, 1'b0, UBEC_HS_DATA);
    ck({7'h0, host.last.data1}, 8'h00);
    host.send(UBEC_EV_IN_ACK, 3'h1, 1'b0);
    ck(8'(ni), 8'h01);
    rd(ICL, 8'h03, 8'h00);
    ld;
    hs(UBEC_EV_IN_TOKEN, 1'b0, UBEC_HS_DATA);
    ck({7'h0, host.last.data1}, 8'h01);
    // toggle is one here; reset it while the packet waits for a retry
    wr(ICL, 8'h40);
    rd(ICL, 8'h41, 8'h01);
    hs(UBEC_EV_IN_TOKEN, 1'b0, UBEC_HS_DATA);
    ck({7'h0, host.last.data1}, 8'h00);
    host.send(UBEC_EV_IN_ACK, 3'h1, 1'b0);
    // double buffer and flush
    wr(ICH, 8'h21);
    rd(ICH, 8'hff, 8'h21);
    ld;
    rd(ICL, 8'h03, 8'h02);
    ld;
    rd(ICL, 8'h03, 8'h03);
    wr(ICL, 8'h08);
    rd(ICL, 8'h0b, 8'h02);
    wr(ICL, 8'h08);
    rd(ICL, 8'h0b, 8'h00);
    wr(ICH, 8'h20);
    // stall on bulk, ignored on iso
    ld;
    wr(ICL, 8'h10);
    hs(UBEC_EV_IN_TOKEN, 1'b0, UBEC_HS_STALL);
    rd(ICL, 8'h33, 8'h30);
    ck(8'(ni), 8'h03);
    wr(ICL, 8'h00);
    wr(ICH, 8'h60);
    wr(ICL, 8'h10);
    hs(UBEC_EV_IN_TOKEN, 1'b0, UBEC_HS_ZLP);
    rd(ICL, 8'h04, 8'h04);
    wr(ICL, 8'h00);
    // forced toggle completes a packet without ack
    wr(ICH, 8'h28);
    ld;
    hs(UBEC_EV_IN_TOKEN, 1'b0, UBEC_HS_DATA);
    ck({7'h0, host.last.data1}, 8'h01);
    host.send(UBEC_EV_IN_NOACK, 3'h1, 1'b0);
    rd(ICL, 8'h03, 8'h00);
    // auto mark at one unit of 8 bytes
    wr(IMX, 8'h01);
    wr(ICH, 8'ha0);
    for (int i = 0; i < 7; i++) wr(FP1, 8'(i));
    rd(ICL, 8'h01, 8'h00);
    wr(FP1, 8'h07);
    rd(ICL, 8'h01, 8'h01);
    // bulk out: store, full, flush, stall
    hs(UBEC_EV_OUT_OK, 1'b0, UBEC_HS_ACK);
    ck(8'(no), 8'h01);
    rd(OCL, 8'h03, 8'h03);
    hs(UBEC_EV_OUT_OK, 1'b1, UBEC_HS_NAK);
    rd(FP1, 8'hff, 8'ha1);
    wr(OCL, 8'h10);
    rd(OCL, 8'h13, 8'h00);
    wr(OCL, 8'h20);
    hs(UBEC_EV_OUT_OK, 1'b1, UBEC_HS_STALL);
    rd(OCL, 8'h40, 8'h40);
    ck(8'(no), 8'h02);
    wr(OCL, 8'h00);
    rd(OCL, 8'h40, 8'h00);
    // out toggle is one here: reset it, stale pid is acked but dropped
    wr(OCL, 8'h80);
    hs(UBEC_EV_OUT_OK, 1'b1, UBEC_HS_ACK);
    rd(OCL, 8'h01, 8'h00);
    hs(UBEC_EV_OUT_OK, 1'b0, UBEC_HS_ACK);
    rd(OCL, 8'h01, 8'h01);
    wr(OCL, 8'h00);
    // iso out: data error, overrun, error cleared with packet
    wr(OCH, 8'h40);
    host.send(UBEC_EV_OUT_BAD, 3'h1, 1'b0);
    rd(OCL, 8'h0b, 8'h0b);
    host.send(UBEC_EV_OUT_OK, 3'h1, 1'b0);
    rd(OCL, 8'h04, 8'h04);
    wr(OCL, 8'h00);
    rd(OCL, 8'h09, 8'h00);
    close_out;
  end
endmodule
